// [rtl/wdt_pkg.sv]
// Constants, types and helper functions shared by the watchdog block.
// Assumes a 20 MHz system clock and a free-running 1 MHz watchdog oscillator.
package wdt_pkg;

    // Register map; the control register is the only mapped word.
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] CTRL_ADDR = 8'h60;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CU_BIT = 4;
    localparam int EN_BIT = 3;
    localparam int SEL_MSB = 2;
    localparam int SEL_W = 3;
    localparam logic [2:0] SEL_RESET = 3'h0;

    // AXI4-Lite response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Unlock window length in system clock cycles.
    localparam int UNLOCK_CYCLES = 4;
    localparam logic [2:0] UNLOCK_LOAD = 3'(UNLOCK_CYCLES - 1);

    // Oscillator and timeout arithmetic: 16K cycles is two to the fourteenth.
    localparam int OSC_HZ = 1000000;
    localparam int SYS_HZ = 20000000;
    localparam int BASE_LOG2 = 14;
    localparam int CNT_W = 21;
    localparam int STRAP_SETTLE = 3;

    typedef enum logic {WDT_LOCKED, WDT_OPEN} wdt_lock_t;

    // Last counter value before a timeout for a given select code.
    function automatic logic [CNT_W-1:0] wdt_last_count(input logic [SEL_W-1:0] sel);
        logic [CNT_W:0] span;
        span = {{CNT_W{1'b0}}, 1'b1} << (BASE_LOG2 + int'(sel));
        wdt_last_count = span[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
    endfunction : wdt_last_count

endpackage : wdt_pkg

// [rtl/wdt_sync.sv]
// Two-stage synchroniser for slow external levels.
// Assumes inputs change far slower than clk_sys.
`timescale 1ns/100ps
`default_nettype none
module wdt_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : wdt_sync
`default_nettype wire

// [rtl/wdt_top.sv]
// Watchdog timer with timed unlock, AXI4-Lite control register.
// Assumes the core pulses kick for one clk_sys cycle per kick instruction,
// and that osc_in is a free-running oscillator much slower than clk_sys.
//
// Function
// R1 - Counter advances on the 1 MHz watchdog oscillator, not the system clock.
// R2 - A kick clears the counter and restarts the timeout period.
// R3 - Counter is cleared while disabled and on every chip reset.
// R4 - Enabled counter reaching the selected timeout requests a chip reset.
// R5 - The reset request is a single pulse of one system clock cycle.
// R6 - Fuse unprogrammed gives level 1 starting disabled; programmed gives level 2 enabled.
// R7 - In level 2 the watchdog stays enabled and enable reads one.
// R8 - In level 2 no write sequence can disable the watchdog.
// R9 - Control register at 0x60, 8 bits, resets to zero, bits 7:5 read zero.
// R10 - Reserved control bits are read-only and read zero.
// R11 - Change-unlock bit clears by hardware four cycles after being written one.
// R12 - Writing enable one enables; writing zero disables only while unlocked.
// R13 - In level 1 software may enable at any time without unlocking.
// R14 - Timeout select changes only while the change-unlock bit is set.
// R15 - Software unlocks by writing change-unlock and enable both one together.
// R16 - Within four cycles software writes enable and select with change-unlock zero.
// R17 - In level 2 the second write updates only the select, ignoring enable.
// R18 - Select codes 000 to 111 give 16K doubling up to 2048K oscillator cycles.
// R19 - Oscillator crossing is synchronised before it affects the counter.
// R20 - An expired window leaves protected fields unchanged and relocks.
`timescale 1ns/100ps
`default_nettype none
module wdt_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [wdt_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [wdt_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Core and chip
    input wire logic kick,
    input wire logic osc_in,
    input wire logic always_on_fuse,
    output logic wdt_reset_req
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and fuse capture

    logic [1:0] pins_s;
    logic osc_s;
    logic fuse_s;
    logic osc_prev_q;
    logic osc_tick;
    logic level2_q;
    logic strap_done_q;
    logic [1:0] strap_cnt_q;

    wdt_sync #(.WIDTH(2)) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in({always_on_fuse, osc_in}),
        .sync_out(pins_s)
    );

    assign osc_s = pins_s[0];
    assign fuse_s = pins_s[1];
    assign osc_tick = osc_s & ~osc_prev_q; // R1 R19

    // The fuse is caught once the synchroniser has settled after reset release.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            osc_prev_q <= 1'b0;
            level2_q <= 1'b0;
            strap_done_q <= 1'b0;
            strap_cnt_q <= 2'h0;
        end else begin
            osc_prev_q <= osc_s;
            if (!strap_done_q) begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
                if (strap_cnt_q == 2'(wdt_pkg::STRAP_SETTLE)) begin
                    level2_q <= fuse_s; // R6
                    strap_done_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    logic aw_hold_q;
    logic w_hold_q;
    logic [wdt_pkg::AXI_ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic wr_hit;
    logic wr_ctl;
    logic [wdt_pkg::AXI_ADDR_W-1:0] wr_addr;
    logic [7:0] wd;
    logic wr_lane0;
    logic ar_take;
    logic rd_hit;
    logic [7:0] ctrl_rd;

    assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready = ~w_hold_q & ~bvalid_q;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_fire = (aw_hold_q | aw_take) & (w_hold_q | w_take);
    assign wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
    assign wd = w_hold_q ? wdata_q : s_axi_wdata[7:0];
    assign wr_lane0 = w_hold_q ? wstrb0_q : s_axi_wstrb[0];
    assign wr_hit = (wr_addr == wdt_pkg::CTRL_ADDR); // R9
    assign wr_ctl = wr_fire & wr_hit & wr_lane0;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    assign s_axi_arready = ~rvalid_q;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign rd_hit = (s_axi_araddr == wdt_pkg::CTRL_ADDR);
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= wdt_pkg::RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_hold_q <= 1'b1;
                    awaddr_q <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_hold_q <= 1'b1;
                    wdata_q <= s_axi_wdata[7:0];
                    wstrb0_q <= s_axi_wstrb[0];
                end
                if (bvalid_q && s_axi_bready) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= wdt_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_hit ? {24'h00_0000, ctrl_rd} : 32'h0000_0000;
            rresp_q <= rd_hit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register and timed unlock

    wdt_pkg::wdt_lock_t lock_q;
    wdt_pkg::wdt_lock_t lock_d;
    logic [2:0] win_q;
    logic [2:0] win_d;
    logic en_q;
    logic en_d;
    logic [wdt_pkg::SEL_W-1:0] sel_q;
    logic [wdt_pkg::SEL_W-1:0] sel_d;
    logic unlock_wr;
    logic open;
    logic en_eff;

    assign open = (lock_q == wdt_pkg::WDT_OPEN);
    assign unlock_wr = wr_ctl & wd[wdt_pkg::CU_BIT] & wd[wdt_pkg::EN_BIT]; // R15
    assign en_eff = en_q | level2_q; // R7 R8
    assign ctrl_rd = {3'h0, open, en_eff, sel_q}; // R9 R10

    always_comb begin
        lock_d = lock_q;
        win_d = win_q;
        case (lock_q)
            wdt_pkg::WDT_LOCKED: begin
                if (unlock_wr) begin
                    lock_d = wdt_pkg::WDT_OPEN;
                    win_d = wdt_pkg::UNLOCK_LOAD;
                end
            end
            wdt_pkg::WDT_OPEN: begin
                if (wr_ctl && !wd[wdt_pkg::CU_BIT]) begin
                    lock_d = wdt_pkg::WDT_LOCKED; // R16
                end else if (win_q == 3'h0) begin
                    lock_d = wdt_pkg::WDT_LOCKED; // R11 R20
                end else begin
                    win_d = win_q - 3'h1;
                end
            end
            default: begin
                lock_d = wdt_pkg::WDT_LOCKED;
            end
        endcase
    end

    // Enable may be set freely; clearing needs the window and level 1.
    assign en_d = (wr_ctl && wd[wdt_pkg::EN_BIT]) ? 1'b1 : // R12 R13
                  (wr_ctl && open && !level2_q) ? 1'b0 : en_q; // R8 R17
    assign sel_d = (wr_ctl && open && !wd[wdt_pkg::CU_BIT]) ?
                   wd[wdt_pkg::SEL_MSB:0] : sel_q; // R14 R17 R20

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            lock_q <= wdt_pkg::WDT_LOCKED;
            win_q <= 3'h0;
            en_q <= wdt_pkg::CTRL_RESET[wdt_pkg::EN_BIT];
            sel_q <= wdt_pkg::SEL_RESET;
        end else begin
            lock_q <= lock_d;
            win_q <= win_d;
            en_q <= en_d;
            sel_q <= sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timeout counter

    logic [wdt_pkg::CNT_W-1:0] cnt_q;
    logic [wdt_pkg::CNT_W-1:0] cnt_d;
    logic [wdt_pkg::CNT_W-1:0] last_cnt;
    logic expire;

    assign last_cnt = wdt_pkg::wdt_last_count(sel_q); // R18
    assign expire = en_eff & ~kick & osc_tick & (cnt_q == last_cnt); // R4
    assign cnt_d = (!en_eff || kick || expire) ? '0 : // R2 R3
                   osc_tick ? cnt_q + {{(wdt_pkg::CNT_W-1){1'b0}}, 1'b1} : cnt_q; // R1

    // A kick in the tick that would expire wins, so a late kick still saves the chip.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_q <= '0; // R3
            wdt_reset_req <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            wdt_reset_req <= expire; // R5
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    // Counts cycles spent unlocked, so the window length is checked without a long repetition.
    logic [2:0] open_run_q;

    always_ff @(posedge clk_sys) begin
        open_run_q <= (!nrst || !open) ? 3'h0 : open_run_q + 3'h1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence unlock_write_s;
        unlock_wr && !open;
    endsequence

    sequence quiet_window_s;
        (!wr_ctl) [*3];
    endsequence

    req_single_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req) // R5
        else $error("reset request lasted more than one cycle");
    unlock_window_a: assert property (unlock_write_s ##1 quiet_window_s |=> open) // R11
        else $error("unlock window closed too early");
    window_span_a: assert property (open |-> open_run_q < 3'(wdt_pkg::UNLOCK_CYCLES)) // R11 R20
        else $error("unlock window stayed open too long");
    unlock_expiry_a: assert property (unlock_write_s ##1 (!wr_ctl) [*5] |-> !open) // R11 R20
        else $error("unlock bit not cleared after four cycles");
    level2_reads_one_a: assert property (level2_q |-> ctrl_rd[wdt_pkg::EN_BIT]) // R7
        else $error("enable reads zero in level two");
    level2_no_disable_a: assert property (level2_q && en_q |=> en_q) // R8
        else $error("watchdog disabled in level two");
    locked_sel_a: assert property (wr_ctl && !open |=> $stable(sel_q)) // R14
        else $error("select changed while locked");
    locked_en_a: assert property (wr_ctl && !open && en_q |=> en_q) // R12
        else $error("enable cleared while locked");
    enable_write_a: assert property (wr_ctl && wd[wdt_pkg::EN_BIT] |=> en_q) // R12 R13
        else $error("enable write had no effect");
    kick_clears_a: assert property (kick |=> cnt_q == '0) // R2
        else $error("kick did not clear counter");
    disabled_idle_a: assert property (!en_eff |=> cnt_q == '0 && !wdt_reset_req) // R3
        else $error("counter moved while disabled");
    timeout_req_a: assert property (en_eff && osc_tick && !kick && cnt_q == last_cnt
        |=> wdt_reset_req && cnt_q == '0) // R4
        else $error("timeout without reset request");
    reserved_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:5] == '0) // R10
        else $error("reserved bits read nonzero");

endmodule : wdt_top
`default_nettype wire

// [dv/wdt_core_model.sv]
// Core-side model: free-running watchdog oscillator and kick pulses.
// Assumes clk_sys is the system clock; HALF counts system clock cycles.
`timescale 1ns/100ps
`default_nettype none
module wdt_core_model #(
    parameter int HALF = 4
) (
    // Clock
    input wire logic clk_sys,
    // Core side
    input wire logic kick_go,
    output logic kick,
    output logic osc_in
);
    int cnt_q = 0;
    logic osc_q = 1'b0;
    logic kick_q = 1'b0;
    assign osc_in = osc_q;
    assign kick = kick_q;
    // The oscillator never stops, so the block must not rely on it being quiet.
    always @(posedge clk_sys) begin
        cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
        if (cnt_q == HALF - 1) osc_q <= !osc_q;
        kick_q <= kick_go;
    end
endmodule : wdt_core_model
`default_nettype wire

// [dv/wdt_top_tb_top.sv]
// Self-checking bench for the watchdog block.
// Assumes the core model above and the design package are compiled first.
`timescale 1ns/100ps
`default_nettype none
module wdt_top_tb_top;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic aw_v = 1'b0;
    logic w_v = 1'b0;
    logic ar_v = 1'b0;
    logic kick_go = 1'b0;
    logic fuse = 1'b0;
    logic [7:0] aw_a = 8'h00;
    logic [7:0] ar_a = 8'h00;
    logic [31:0] w_d = 32'h0;
    logic aw_r, w_r, b_v, ar_r, r_v, kick, osc, req;
    logic [1:0] b_rs, r_rs;
    logic [31:0] r_d;
    int err_count = 0;
    int cmp_count = 0;
    logic b_rdy = 1'b0;
    logic r_rdy = 1'b0;
    logic [3:0] w_s = 4'h1;
    localparam int OSC_HALF = 2;
    localparam int TICK = 2 * OSC_HALF;

    always #25 clk_sys = ~clk_sys;

    wdt_core_model #(.HALF(OSC_HALF)) i_core (.clk_sys(clk_sys), .kick_go(kick_go), .kick(kick),
        .osc_in(osc));

    // Only the protection inputs are tied: the block ignores them.
    wdt_top i_dut (.clk_sys(clk_sys), .nrst(nrst),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
        .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_wdata(w_d), .s_axi_wstrb(w_s),
        .s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_bresp(b_rs),
        .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0),
        .s_axi_rvalid(r_v), .s_axi_rready(r_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_rs),
        .kick(kick), .osc_in(osc), .always_on_fuse(fuse), .wdt_reset_req(req));

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic hang();
        chk(32'h0, 32'h1);
        close_out();
    endtask : hang

    task automatic do_reset(input logic f);
        nrst <= 1'b0;
        fuse <= f;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask : do_reset

    // Pre-edge values are sampled at the falling edge, where nothing moves.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, hb;
        logic [1:0] rs;
        hb = 1'b0;
        aw_a <= a;
        w_d <= {24'h0, d};
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_rdy <= 1'b1;
        for (int n = 0; n < 50 && !hb; n++) begin
            @(negedge clk_sys);
            ta = aw_v && aw_r;
            tw = w_v && w_r;
            hb = b_v;
            rs = b_rs;
            @(posedge clk_sys);
            if (ta) aw_v <= 1'b0;
            if (tw) w_v <= 1'b0;
        end
        if (!hb) hang();
        b_rdy <= 1'b0;
        @(posedge clk_sys);
        chk({30'h0, rs}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        logic ta, hv;
        logic [31:0] dv;
        logic [1:0] rs;
        hv = 1'b0;
        ar_a <= a;
        ar_v <= 1'b1;
        r_rdy <= 1'b1;
        for (int n = 0; n < 50 && !hv; n++) begin
            @(negedge clk_sys);
            ta = ar_v && ar_r;
            hv = r_v;
            dv = r_d;
            rs = r_rs;
            @(posedge clk_sys);
            if (ta) ar_v <= 1'b0;
        end
        if (!hv) hang();
        r_rdy <= 1'b0;
        @(posedge clk_sys);
        chk(dv, {24'h0, ed});
        chk({30'h0, rs}, {30'h0, er});
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(wdt_pkg::CTRL_ADDR, 8'h00, wdt_pkg::RESP_OKAY);
        rd(8'h64, 8'h00, wdt_pkg::RESP_SLVERR);
        wr(8'h64, 8'h08, wdt_pkg::RESP_SLVERR);
        wr(wdt_pkg::CTRL_ADDR, 8'he7, wdt_pkg::RESP_OKAY);
        rd(wdt_pkg::CTRL_ADDR, 8'h00, wdt_pkg::RESP_OKAY);
        w_s <= 4'he;
        wr(wdt_pkg::CTRL_ADDR, 8'h08, wdt_pkg::RESP_OKAY);
        rd(wdt_pkg::CTRL_ADDR, 8'h00, wdt_pkg::RESP_OKAY);
        w_s <= 4'h1;
        wr(wdt_pkg::CTRL_ADDR, 8'h08, wdt_pkg::RESP_OKAY);
        rd(wdt_pkg::CTRL_ADDR, 8'h08, wdt_pkg::RESP_OKAY);
        wr(wdt_pkg::CTRL_ADDR, 8'h18, wdt_pkg::RESP_OKAY);
        wr(wdt_pkg::CTRL_ADDR, 8'h05, wdt_pkg::RESP_OKAY);
        rd(wdt_pkg::CTRL_ADDR, 8'h05, wdt_pkg::RESP_OKAY);
        wr(wdt_pkg::CTRL_ADDR, 8'h0a, wdt_pkg::RESP_OKAY);
        rd(wdt_pkg::CTRL_ADDR, 8'h0d, wdt_pkg::RESP_OKAY);
        wr(wdt_pkg::CTRL_ADDR, 8'h18, wdt_pkg::RESP_OKAY);
        repeat (6) @(posedge clk_sys);
        wr(wdt_pkg::CTRL_ADDR, 8'h01, wdt_pkg::RESP_OKAY);
        rd(wdt_pkg::CTRL_ADDR, 8'h0d, wdt_pkg::RESP_OKAY);
    endtask : t_regs

    task automatic t_sel();
        for (int s = 7; s >= 0; s--) begin
            wr(wdt_pkg::CTRL_ADDR, 8'h18, wdt_pkg::RESP_OKAY);
            wr(wdt_pkg::CTRL_ADDR, 8'h08 | 8'(s), wdt_pkg::RESP_OKAY);
            rd(wdt_pkg::CTRL_ADDR, 8'h08 | 8'(s), wdt_pkg::RESP_OKAY);
        end
    endtask : t_sel

    task automatic t_lvl2();
        do_reset(1'b1);
        rd(wdt_pkg::CTRL_ADDR, 8'h08, wdt_pkg::RESP_OKAY);
        wr(wdt_pkg::CTRL_ADDR, 8'h00, wdt_pkg::RESP_OKAY);
        rd(wdt_pkg::CTRL_ADDR, 8'h08, wdt_pkg::RESP_OKAY);
        wr(wdt_pkg::CTRL_ADDR, 8'h18, wdt_pkg::RESP_OKAY);
        wr(wdt_pkg::CTRL_ADDR, 8'h03, wdt_pkg::RESP_OKAY);
        rd(wdt_pkg::CTRL_ADDR, 8'h0b, wdt_pkg::RESP_OKAY);
    endtask : t_lvl2

    // One tick is four system cycles, so select 0 times out near 65536 cycles.
    task automatic t_tmo();
        int n;
        int exp_n;
        exp_n = TICK << wdt_pkg::BASE_LOG2;
        do_reset(1'b0);
        wr(wdt_pkg::CTRL_ADDR, 8'h08, wdt_pkg::RESP_OKAY);
        repeat (1000) @(posedge clk_sys);
        kick_go <= 1'b1;
        @(posedge clk_sys);
        kick_go <= 1'b0;
        n = 0;
        while (n < 70000 && req !== 1'b1) begin
            @(negedge clk_sys);
            n++;
        end
        if (req !== 1'b1) hang();
        chk({31'h0, n > exp_n - TICK - 2 && n < exp_n + TICK}, 32'h1);
        @(negedge clk_sys);
        chk({31'h0, req}, 32'h0);
    endtask : t_tmo

    initial begin
        do_reset(1'b0);
        t_regs();
        t_sel();
        t_lvl2();
        t_tmo();
        close_out();
    end
endmodule : wdt_top_tb_top
`default_nettype wire
